// ===== rtl/lcd_ladder_pkg.sv
// constants and types shared by the pixel map and ladder control design
package lcd_ladder_pkg;
   // register indices (byte address is four times the index)
   localparam logic [7:0] IDX_PIXEL_BASE = 8'h00;
   localparam logic [7:0] IDX_LADDER = 8'h20;
   localparam logic [7:0] IDX_CONTROL = 8'h21;
   localparam logic [7:0] IDX_STATUS = 8'h22;
   localparam logic [7:0] IDX_IRQ_MASK = 8'h23;
   localparam int PIXEL_WORDS = 32;
   localparam int WORD_BITS = 16;
   localparam int WORDS_PER_COMMON = 4;
   localparam int COMMONS = 8;
   // reference ladder control field positions
   localparam int IRE_BIT = 15;
   localparam int CST_HI = 13;
   localparam int CST_LO = 11;
   localparam int BIAS3_BIT = 10;
   localparam int BIAS2_BIT = 9;
   localparam int BIAS1_BIT = 8;
   localparam int APWR_HI = 7;
   localparam int APWR_LO = 6;
   localparam int BPWR_HI = 5;
   localparam int BPWR_LO = 4;
   localparam int ALEN_HI = 2;
   localparam int ALEN_LO = 0;
   localparam logic [15:0] LADDER_WMASK = 16'hBFF7;
   localparam logic [15:0] LADDER_RESET = 16'h0000;
   // control register: bits 2:0 commons select, bit 7 waveform type
   localparam int CSEL_HI = 2;
   localparam int CSEL_LO = 0;
   localparam int WFT_BIT = 7;
   // status/interrupt bit positions
   localparam int ST_WFAIL = 0;
   localparam int ST_PERIOD = 1;
   localparam int ST_BITS = 2;
   // ladder period lengths in LCD clocks
   localparam logic [5:0] PERIOD_TYPE_A = 6'h10;
   localparam logic [5:0] PERIOD_TYPE_B = 6'h20;
   typedef enum logic [1:0] {
      PWR_OFF = 2'b00,
      PWR_LOW = 2'b01,
      PWR_MED = 2'b10,
      PWR_HIGH = 2'b11
   } power_t;
endpackage : lcd_ladder_pkg

// ===== rtl/pixel_mem_if.sv
// write and read port bundle between the top and the pixel memory
`timescale 1ns/1ps
interface pixel_mem_if;
   logic wr_en;
   logic [4:0] wr_addr;
   logic [15:0] wr_data;
   logic [4:0] rd_addr;
   logic [15:0] rd_data;
   modport owner (output wr_en, output wr_addr, output wr_data, output rd_addr,
      input rd_data);
   modport mem (input wr_en, input wr_addr, input wr_data, input rd_addr,
      output rd_data);
endinterface : pixel_mem_if

// ===== rtl/pixel_mem.sv
// pixel data word memory, 32 words of 16 bits, registered read
`timescale 1ns/1ps
module pixel_mem
   import lcd_ladder_pkg::*;
(
   input wire logic clk_in,
   input wire logic rstn_in,
   pixel_mem_if.mem port,
   output logic [PIXEL_WORDS*WORD_BITS-1:0] all_out
);
   typedef struct packed {
      logic [PIXEL_WORDS-1:0][WORD_BITS-1:0] word;
      logic [WORD_BITS-1:0] rd;
   } mem_state_t;
   mem_state_t s_q, s_d;

   // store writes, register the addressed word for the bus read
   always_comb begin
      s_d = s_q;
      if (port.wr_en) begin
         s_d.word[port.wr_addr] = port.wr_data;
      end
      s_d.rd = s_q.word[port.rd_addr];
   end

   always_ff @(posedge clk_in) begin
      if (!rstn_in) begin
         s_q <= '0;
      end else begin
         s_q <= s_d;
      end
   end

   assign port.rd_data = s_q.rd;
   assign all_out = s_q.word;
endmodule : pixel_mem

// ===== rtl/lcd_ladder_ctrl.sv
// pixel map, reference ladder control and interval sequencer of the lcd driver
`timescale 1ns/1ps
module lcd_ladder_ctrl
   import lcd_ladder_pkg::*;
(
   input wire logic SYS_CLK_IN,
   input wire logic RSTN_IN,
   input wire logic LCD_TICK_IN,
   input wire logic WRITE_ALLOW_IN,
   input wire logic [7:0] ADDR_IN,
   input wire logic [15:0] WDATA_IN,
   input wire logic WR_IN,
   input wire logic RD_IN,
   output logic [15:0] RDATA_OUT,
   output logic [PIXEL_WORDS*WORD_BITS-1:0] PIXEL_OUT,
   output logic REF_ENABLE_OUT,
   output logic [2:0] CONTRAST_OUT,
   output logic [2:0] BIAS_PIN_ROUTE_OUT,
   output logic [1:0] LADDER_POWER_OUT,
   output logic INTERVAL_A_OUT,
   output logic WAVEFORM_TYPE_OUT,
   output logic [2:0] COMMONS_SELECT_OUT,
   output logic IRQ_OUT
);
   typedef struct packed {
      logic [15:0] ladder;
      logic [2:0] csel;
      logic waveform_type;
      logic [ST_BITS-1:0] status;
      logic [ST_BITS-1:0] mask;
      logic [5:0] count;
      logic in_a;
      logic [15:0] rdata;
      logic rd_pix;
   } state_t;
   state_t s_q, s_d;

   pixel_mem_if pm ();
   logic [PIXEL_WORDS*WORD_BITS-1:0] pix_all;
   logic pix_wr, is_pix, pix_fail;
   logic [2:0] alen;
   logic [5:0] period;
   logic [5:0] next_count;
   logic period_end;

   pixel_mem u_mem (
      .clk_in(SYS_CLK_IN),
      .rstn_in(RSTN_IN),
      .port(pm.mem),
      .all_out(pix_all)
   );

   // pixel decode: the low 32 indices are pixel words
   assign is_pix = (ADDR_IN < IDX_PIXEL_BASE + 8'(PIXEL_WORDS));
   assign pix_wr = WR_IN && is_pix && WRITE_ALLOW_IN;
   assign pix_fail = WR_IN && is_pix && !WRITE_ALLOW_IN;
   assign pm.wr_en = pix_wr;
   assign pm.wr_addr = ADDR_IN[4:0];
   assign pm.wr_data = WDATA_IN;
   assign pm.rd_addr = ADDR_IN[4:0];

   // period length from waveform type, interval code from the ladder word
   assign alen = s_q.ladder[ALEN_HI:ALEN_LO];
   assign period = s_q.waveform_type ? PERIOD_TYPE_B : PERIOD_TYPE_A;
   assign period_end = LCD_TICK_IN && (s_q.count >= period - 6'h01);
   assign next_count = period_end ? 6'h00 : s_q.count + 6'h01;

   // next state: registers, interval sequencer, status
   always_comb begin
      s_d = s_q;
      s_d.rd_pix = 1'b0;
      if (WR_IN) begin
         unique case (ADDR_IN)
            IDX_LADDER: s_d.ladder = WDATA_IN & LADDER_WMASK;
            IDX_CONTROL: begin
               s_d.csel = WDATA_IN[CSEL_HI:CSEL_LO];
               s_d.waveform_type = WDATA_IN[WFT_BIT];
            end
            IDX_IRQ_MASK: s_d.mask = WDATA_IN[ST_BITS-1:0];
            default: ;
         endcase
      end
      // read data, with a read of status clearing it
      if (RD_IN) begin
         s_d.rdata = 16'h0000;
         s_d.rd_pix = is_pix;
         unique case (ADDR_IN)
            IDX_LADDER: s_d.rdata = s_q.ladder;
            IDX_CONTROL: s_d.rdata = {8'h00, s_q.waveform_type, 4'h0, s_q.csel};
            IDX_STATUS: begin
               s_d.rdata = {14'h0000, s_q.status};
               s_d.status = '0;
            end
            IDX_IRQ_MASK: s_d.rdata = {14'h0000, s_q.mask};
            default: ;
         endcase
      end
      // interval sequencer advances on the lcd clock enable
      if (LCD_TICK_IN) begin
         s_d.count = next_count;
      end
      // power-A covers counts 0..N-1 of the code about to stand; worked out every cycle
      // so that a new code of zero leaves A at once instead of at the next tick
      s_d.in_a = (s_d.ladder[ALEN_HI:ALEN_LO] != 3'h0)
         && (s_d.count < {3'h0, s_d.ladder[ALEN_HI:ALEN_LO]});
      // events set after any clear so that set wins
      if (pix_fail) begin
         s_d.status[ST_WFAIL] = 1'b1;
      end
      if (period_end) begin
         s_d.status[ST_PERIOD] = 1'b1;
      end
   end

   always_ff @(posedge SYS_CLK_IN) begin
      if (!RSTN_IN) begin
         s_q <= '0;
      end else begin
         s_q <= s_d;
      end
   end

   // pixels of commons outside the multiplex count are masked from the drive
   always_comb begin
      PIXEL_OUT = pix_all;
      for (int w = 0; w < PIXEL_WORDS; w++) begin
         if ((w / WORDS_PER_COMMON) > int'(s_q.csel)) begin
            PIXEL_OUT[w*WORD_BITS +: WORD_BITS] = '0;
         end
      end
   end

   // outputs straight from the ladder and control words, sequencer, read data and status
   assign REF_ENABLE_OUT = s_q.ladder[IRE_BIT];
   assign CONTRAST_OUT = s_q.ladder[CST_HI:CST_LO];
   assign BIAS_PIN_ROUTE_OUT = {s_q.ladder[BIAS3_BIT], s_q.ladder[BIAS2_BIT],
      s_q.ladder[BIAS1_BIT]};
   assign LADDER_POWER_OUT = s_q.in_a ? s_q.ladder[APWR_HI:APWR_LO]
      : s_q.ladder[BPWR_HI:BPWR_LO];
   assign INTERVAL_A_OUT = s_q.in_a;
   assign WAVEFORM_TYPE_OUT = s_q.waveform_type;
   assign COMMONS_SELECT_OUT = s_q.csel;
   assign RDATA_OUT = s_q.rd_pix ? pm.rd_data : s_q.rdata;
   assign IRQ_OUT = |(s_q.status & s_q.mask);

   // checks: named steps of the register bus and of the interval sequencer
   sequence seq_ladder_wr;
      WR_IN && (ADDR_IN == IDX_LADDER);
   endsequence
   sequence seq_ladder_rd;
      RD_IN && (ADDR_IN == IDX_LADDER);
   endsequence
   sequence seq_control_wr;
      WR_IN && (ADDR_IN == IDX_CONTROL);
   endsequence
   sequence seq_mask_wr;
      WR_IN && (ADDR_IN == IDX_IRQ_MASK);
   endsequence
   sequence seq_status_rd;
      RD_IN && (ADDR_IN == IDX_STATUS);
   endsequence
   sequence seq_pixel_rd;
      RD_IN && is_pix;
   endsequence
   sequence seq_allowed_wr;
      WR_IN && is_pix && WRITE_ALLOW_IN;
   endsequence
   // a tick either steps the count or closes the period
   sequence seq_tick_mid;
      LCD_TICK_IN && !period_end;
   endsequence
   sequence seq_tick_wrap;
      LCD_TICK_IN && period_end;
   endsequence

   // core sequencer, write-refusal and reference enable write checks
   chk_zero_never_a: assert property (@(posedge SYS_CLK_IN) disable iff (!RSTN_IN)
      (alen == 3'h0) |-> !INTERVAL_A_OUT)
      else $error("interval A entered with zero length code");
   chk_fail_flag_set: assert property (@(posedge SYS_CLK_IN) disable iff (!RSTN_IN)
      pix_fail |=> s_q.status[ST_WFAIL])
      else $error("write fail flag not set");
   chk_blocked_write: assert property (@(posedge SYS_CLK_IN) disable iff (!RSTN_IN)
      pix_fail |=> $stable(pix_all))
      else $error("pixel write went through without allow");
   chk_power_a_sel: assert property (@(posedge SYS_CLK_IN) disable iff (!RSTN_IN)
      INTERVAL_A_OUT |-> LADDER_POWER_OUT == s_q.ladder[APWR_HI:APWR_LO])
      else $error("interval A power wrong");
   chk_power_b_sel: assert property (@(posedge SYS_CLK_IN) disable iff (!RSTN_IN)
      !INTERVAL_A_OUT |-> LADDER_POWER_OUT == s_q.ladder[BPWR_HI:BPWR_LO])
      else $error("interval B power wrong");
   chk_count_bound: assert property (@(posedge SYS_CLK_IN) disable iff (!RSTN_IN)
      s_q.count < PERIOD_TYPE_B)
      else $error("period count overran");
   chk_a_first: assert property (@(posedge SYS_CLK_IN) disable iff (!RSTN_IN)
      LCD_TICK_IN && period_end && (alen != 3'h0) |=> INTERVAL_A_OUT)
      else $error("period did not start in interval A");
   chk_a_length: assert property (@(posedge SYS_CLK_IN) disable iff (!RSTN_IN)
      INTERVAL_A_OUT |-> s_q.count < {3'h0, alen})
      else $error("interval A too long");
   chk_ladder_write: assert property (@(posedge SYS_CLK_IN) disable iff (!RSTN_IN)
      seq_ladder_wr |=> REF_ENABLE_OUT == $past(WDATA_IN[IRE_BIT]))
      else $error("reference enable not taken from write");

   // register writes land at the taking edge and nothing else moves the fields;
   // a stray change here would shift the panel bias without software asking
   chk_contrast_wr: assert property (
      @(posedge SYS_CLK_IN) disable iff (!RSTN_IN)
      seq_ladder_wr |=> CONTRAST_OUT == $past(WDATA_IN[CST_HI:CST_LO]))
      else $error("contrast code not taken from write");
   chk_route_wr: assert property (
      @(posedge SYS_CLK_IN) disable iff (!RSTN_IN)
      seq_ladder_wr |=> BIAS_PIN_ROUTE_OUT == $past(WDATA_IN[BIAS3_BIT:BIAS1_BIT]))
      else $error("bias routes not taken from write");
   chk_bias1_route: assert property (
      @(posedge SYS_CLK_IN) disable iff (!RSTN_IN)
      seq_ladder_wr |=> BIAS_PIN_ROUTE_OUT[0] == $past(WDATA_IN[BIAS1_BIT]))
      else $error("bias level 1 route wrong");
   chk_ctrl_wft: assert property (
      @(posedge SYS_CLK_IN) disable iff (!RSTN_IN)
      seq_control_wr |=> WAVEFORM_TYPE_OUT == $past(WDATA_IN[WFT_BIT]))
      else $error("waveform type not taken from write");
   chk_ctrl_csel: assert property (
      @(posedge SYS_CLK_IN) disable iff (!RSTN_IN)
      seq_control_wr |=> COMMONS_SELECT_OUT == $past(WDATA_IN[CSEL_HI:CSEL_LO]))
      else $error("commons select not taken from write");
   chk_mask_wr: assert property (
      @(posedge SYS_CLK_IN) disable iff (!RSTN_IN)
      seq_mask_wr |=> s_q.mask == $past(WDATA_IN[ST_BITS-1:0]))
      else $error("interrupt mask not taken from write");
   chk_ref_hold: assert property (
      @(posedge SYS_CLK_IN) disable iff (!RSTN_IN)
      !(WR_IN && (ADDR_IN == IDX_LADDER)) |=> $stable(s_q.ladder))
      else $error("ladder word changed without a write");
   chk_ctrl_hold: assert property (
      @(posedge SYS_CLK_IN) disable iff (!RSTN_IN)
      !(WR_IN && (ADDR_IN == IDX_CONTROL)) |=> $stable(s_q.csel) && $stable(s_q.waveform_type))
      else $error("control word changed without a write");

   // read data stand in the cycle after the read strobe
   chk_ladder_rd: assert property (
      @(posedge SYS_CLK_IN) disable iff (!RSTN_IN)
      seq_ladder_rd |=> RDATA_OUT == $past(s_q.ladder))
      else $error("ladder read data wrong");
   chk_pixel_rd: assert property (
      @(posedge SYS_CLK_IN) disable iff (!RSTN_IN)
      seq_pixel_rd |=> RDATA_OUT == $past(pix_all[ADDR_IN[4:0]*WORD_BITS +: WORD_BITS]))
      else $error("pixel read data wrong");

   // pixel memory: allowed writes land; the fail flag sticks until a status read
   chk_allowed_wr: assert property (
      @(posedge SYS_CLK_IN) disable iff (!RSTN_IN)
      seq_allowed_wr |=>
         pix_all[$past(ADDR_IN[4:0])*WORD_BITS +: WORD_BITS] == $past(WDATA_IN))
      else $error("allowed pixel write lost");
   chk_fail_sticky: assert property (
      @(posedge SYS_CLK_IN) disable iff (!RSTN_IN)
      s_q.status[ST_WFAIL] && !(RD_IN && (ADDR_IN == IDX_STATUS)) |=> s_q.status[ST_WFAIL])
      else $error("write fail flag dropped by itself");
   chk_status_clear: assert property (
      @(posedge SYS_CLK_IN) disable iff (!RSTN_IN)
      seq_status_rd ##0 (!pix_fail && !period_end) |=> s_q.status == '0)
      else $error("status not cleared by its read");
   chk_irq_masked: assert property (
      @(posedge SYS_CLK_IN) disable iff (!RSTN_IN)
      s_q.status[ST_WFAIL] && s_q.mask[ST_WFAIL] |-> IRQ_OUT)
      else $error("unmasked write fail gave no interrupt");

   // drive mask: common 0 always reaches the glass, the rest only when selected
   chk_pix_mask_top: assert property (
      @(posedge SYS_CLK_IN) disable iff (!RSTN_IN)
      (s_q.csel == 3'h0) |->
         PIXEL_OUT[PIXEL_WORDS*WORD_BITS-1:WORDS_PER_COMMON*WORD_BITS] == '0)
      else $error("unused commons reached the drive");
   chk_pix_pass_low: assert property (
      @(posedge SYS_CLK_IN) disable iff (!RSTN_IN)
      PIXEL_OUT[WORDS_PER_COMMON*WORD_BITS-1:0] == pix_all[WORDS_PER_COMMON*WORD_BITS-1:0])
      else $error("common 0 pixels not driven");

   // sequencer count: one step per tick, wrap at the period of the waveform type;
   // a write of the length or type never restarts the count on its own
   chk_count_step: assert property (
      @(posedge SYS_CLK_IN) disable iff (!RSTN_IN)
      seq_tick_mid |=> s_q.count == $past(s_q.count) + 6'h01)
      else $error("count did not step on a tick");
   chk_count_wrap: assert property (
      @(posedge SYS_CLK_IN) disable iff (!RSTN_IN)
      seq_tick_wrap |=> s_q.count == 6'h00)
      else $error("count did not restart at period end");
   chk_count_hold: assert property (
      @(posedge SYS_CLK_IN) disable iff (!RSTN_IN)
      !LCD_TICK_IN |=> $stable(s_q.count))
      else $error("count moved without a tick");
   chk_period_flag: assert property (
      @(posedge SYS_CLK_IN) disable iff (!RSTN_IN)
      seq_tick_wrap |=> s_q.status[ST_PERIOD])
      else $error("period end not flagged");
   chk_type_a_wrap: assert property (
      @(posedge SYS_CLK_IN) disable iff (!RSTN_IN)
      LCD_TICK_IN && !s_q.waveform_type && (s_q.count == PERIOD_TYPE_A - 6'h01) |-> period_end)
      else $error("type A period too long");
   chk_type_b_wrap: assert property (
      @(posedge SYS_CLK_IN) disable iff (!RSTN_IN)
      LCD_TICK_IN && s_q.waveform_type && (s_q.count == PERIOD_TYPE_B - 6'h01) |-> period_end)
      else $error("type B period too long");
   chk_type_b_mid: assert property (
      @(posedge SYS_CLK_IN) disable iff (!RSTN_IN)
      LCD_TICK_IN && s_q.waveform_type && (s_q.count == PERIOD_TYPE_A - 6'h01) |-> !period_end)
      else $error("type B period cut at sixteen");

   // interval A: only with a nonzero code, and left exactly when the count reaches it
   chk_a_then_b: assert property (
      @(posedge SYS_CLK_IN) disable iff (!RSTN_IN)
      $fell(INTERVAL_A_OUT) && $stable(alen) |-> s_q.count == {3'h0, alen})
      else $error("interval A left at the wrong count");
   chk_a_needs_code: assert property (
      @(posedge SYS_CLK_IN) disable iff (!RSTN_IN)
      INTERVAL_A_OUT |-> alen != 3'h0)
      else $error("interval A with zero length code");
   chk_b_zero: assert property (
      @(posedge SYS_CLK_IN) disable iff (!RSTN_IN)
      (alen == 3'h0) |-> LADDER_POWER_OUT == s_q.ladder[BPWR_HI:BPWR_LO])
      else $error("zero length code left interval B power");
endmodule : lcd_ladder_ctrl

// ===== bench/lcd_panel_model.sv
// glass panel model: counts the pixels that the drive lights
`timescale 1ns/1ps
module lcd_panel_model
   import lcd_ladder_pkg::*;
(
   input wire logic [PIXEL_WORDS*WORD_BITS-1:0] pixel_in,
   output logic [9:0] lit_out
);
   // the glass sees only driven words; masked commons stay dark
   always_comb begin
      lit_out = 10'h000;
      for (int w = 0; w < PIXEL_WORDS; w++) begin
         lit_out += 10'($countones(pixel_in[w*WORD_BITS +: WORD_BITS]));
      end
   end
endmodule : lcd_panel_model

// ===== bench/lcd_pixel_map_and_ladder_control_test.sv
// self-checking bench for the pixel map and ladder control block
`timescale 1ns/1ps
module lcd_pixel_map_and_ladder_control_test
   import lcd_ladder_pkg::*;
   ;
   logic clk = 1'b0, rstn = 1'b0, tick = 1'b0, wa = 1'b1, wr = 1'b0, rd = 1'b0;
   logic [7:0] addr = 8'h00;
   logic [15:0] wdata = 16'h0000, rdata, seen;
   logic [PIXEL_WORDS*WORD_BITS-1:0] pix;
   logic ref_en, in_a, waveform_type, irq;
   logic [2:0] cst, route, csel;
   logic [1:0] pwr;
   logic [9:0] lit;
   logic [15:0] mem [PIXEL_WORDS];
   int n_errors = 0, checks = 0, cyc = 0;
   // clock source
   initial begin
      forever #12.5 clk = ~clk;
   end
   lcd_ladder_ctrl dut (.SYS_CLK_IN(clk), .RSTN_IN(rstn), .LCD_TICK_IN(tick),
      .WRITE_ALLOW_IN(wa), .ADDR_IN(addr), .WDATA_IN(wdata), .WR_IN(wr), .RD_IN(rd),
      .RDATA_OUT(rdata), .PIXEL_OUT(pix), .REF_ENABLE_OUT(ref_en), .CONTRAST_OUT(cst),
      .BIAS_PIN_ROUTE_OUT(route), .LADDER_POWER_OUT(pwr), .INTERVAL_A_OUT(in_a),
      .WAVEFORM_TYPE_OUT(waveform_type), .COMMONS_SELECT_OUT(csel), .IRQ_OUT(irq));
   lcd_panel_model panel (.pixel_in(pix), .lit_out(lit));
   task automatic report_and_stop();
      $display("checks %0d errors %0d", checks, n_errors);
      if (n_errors == 0 && checks > 0) begin
         $display("verification passed");
      end else begin
         $display("verification failed");
      end
      $finish;
   endtask : report_and_stop
   task automatic chk(input string name, input logic [15:0] s, input logic [15:0] e);
      checks++;
      if (s !== e) begin
         n_errors++;
         $display("[ERR] %s expected %h seen %h", name, e, s);
      end
   endtask : chk
   // bus cycles end one step past the taking edge so outputs have landed
   task automatic wr_reg(input logic [7:0] a, input logic [15:0] d);
      @(posedge clk);
      addr <= a;
      wdata <= d;
      wr <= 1'b1;
      @(posedge clk);
      wr <= 1'b0;
      #1;
   endtask : wr_reg
   task automatic rd_reg(input logic [7:0] a, output logic [15:0] d);
      @(posedge clk);
      addr <= a;
      rd <= 1'b1;
      @(posedge clk);
      rd <= 1'b0;
      #1 d = rdata;
   endtask : rd_reg
   task automatic pulse();
      @(posedge clk);
      tick <= 1'b1;
      @(posedge clk);
      tick <= 1'b0;
      @(posedge clk);
      #1;
   endtask : pulse
   // lit count the glass should show for a commons selection
   function automatic logic [15:0] exp_lit(input logic [2:0] cs);
      int s = 0;
      for (int w = 0; w < PIXEL_WORDS; w++) begin
         if (w / WORDS_PER_COMMON <= cs) s += $countones(mem[w]);
      end
      return 16'(s);
   endfunction : exp_lit
   // hang guard, far above the expected run
   always @(posedge clk) begin
      cyc++;
      if (cyc == 20000) begin
         n_errors++;
         report_and_stop();
      end
   end
   initial begin
      logic [15:0] v;
      logic [2:0] cs;
      logic prev;
      int w, k, ups;
      foreach (mem[i]) mem[i] = 16'h0000;
      void'($urandom(59));
      repeat (8) @(posedge clk);
      rstn <= 1'b1;
      rd_reg(IDX_LADDER, seen); chk("ladder_rst", seen, 16'h0000);
      rd_reg(8'h30, seen); chk("unmapped", seen, 16'h0000);
      // all-ones first, then random ladder settings
      for (int i = 0; i < 6; i++) begin
         v = (i == 0) ? 16'hFFFF : 16'($urandom);
         wr_reg(IDX_LADDER, v);
         rd_reg(IDX_LADDER, seen); chk("ladder_rd", seen, v & 16'hBFF7);
         chk("ref_en", 16'(ref_en), 16'(v[15]));
         chk("contrast", 16'(cst), 16'(v[13:11]));
         chk("route", 16'(route), 16'(v[10:8]));
      end
      // pixel words: last word of every common, then random ones
      for (int i = 0; i < 12; i++) begin
         w = (i < 8) ? i * 4 + 3 : int'($urandom % PIXEL_WORDS);
         v = 16'($urandom);
         cs = 3'($urandom);
         wr_reg(IDX_CONTROL, {13'h0000, cs});
         wr_reg(8'(w), v);
         mem[w] = v;
         rd_reg(8'(w), seen); chk("pix_rd", seen, v);
         chk("csel", 16'(csel), 16'(cs));
         chk("pix_out", pix[w*16 +: 16], (w / 4 <= cs) ? v : 16'h0000);
         chk("lit", 16'(lit), exp_lit(cs));
      end
      // refused write while write-allow is low
      wr_reg(IDX_IRQ_MASK, 16'h0001);
      @(posedge clk) wa <= 1'b0;
      wr_reg(8'h05, 16'hA5A5);
      @(posedge clk);
      #1 chk("irq", 16'(irq), 16'h0001);
      rd_reg(8'h05, seen); chk("dropped", seen, mem[5]);
      rd_reg(IDX_STATUS, seen); chk("wfail", seen & 16'h0001, 16'h0001);
      rd_reg(IDX_STATUS, seen); chk("wfail_clr", seen & 16'h0001, 16'h0000);
      chk("irq_clr", 16'(irq), 16'h0000);
      @(posedge clk) wa <= 1'b1;
      // every length code under both waveform types
      for (int t = 0; t < 2; t++) begin
         wr_reg(IDX_CONTROL, {8'h00, 1'(t), 4'h0, 3'h7});
         chk("wft", 16'(waveform_type), 16'(t));
         for (int n = 0; n < 8; n++) begin
            v = (16'($urandom) & 16'h00F0) | 16'(n);
            wr_reg(IDX_LADDER, v);
            pulse();
            prev = in_a;
            k = 0;
            ups = 0;
            repeat (t ? 32 : 16) begin
               pulse();
               k += (in_a === 1'b1);
               ups += (in_a === 1'b1 && prev !== 1'b1);
               prev = in_a;
               chk("power", 16'(pwr), in_a ? 16'(v[7:6]) : 16'(v[5:4]));
            end
            chk("a_clocks", 16'(k), 16'(n));
            chk("a_runs", 16'(ups), 16'(n != 0));
         end
      end
      rd_reg(IDX_STATUS, seen); chk("period", seen & 16'h0002, 16'h0002);
      // reset in mid-run clears registers, sequencer and pixel memory
      @(posedge clk) rstn <= 1'b0;
      repeat (2) @(posedge clk);
      rstn <= 1'b1;
      rd_reg(IDX_LADDER, seen); chk("ladder_rst2", seen, 16'h0000);
      chk("in_a_rst", 16'(in_a), 16'h0000);
      chk("lit_rst", 16'(lit), 16'h0000);
      report_and_stop();
   end
endmodule : lcd_pixel_map_and_ladder_control_test
